// ==== rtl/dcf_consts.vh ====
// constants for the dual-clock fifo core with mailboxes
// included by rtl/dcf_fifo.v only; definitions only
`ifndef DCF_CONSTS_VH
`define DCF_CONSTS_VH

`define DCF_DATA_W 36
`define DCF_DEPTH 64
`define DCF_ADDR_W 6
`define DCF_PTR_W 7

// almost-empty / almost-full offset, by {offset_select_hi, offset_select_lo}
`define DCF_OFS_HH 7'h10
`define DCF_OFS_HL 7'h0c
`define DCF_OFS_LH 7'h08
`define DCF_OFS_LL 7'h04
`define DCF_OFS_RST 7'h04

// flag values held during reset
`define DCF_FULL_N_RST 1'b0
`define DCF_EMPTY_N_RST 1'b0
`define DCF_AEMPTY_N_RST 1'b0
`define DCF_AFULL_N_RST 1'b1
`define DCF_MBOX_N_RST 1'b1

`endif

// ==== rtl/dcf_fifo.v ====
// dual-port 64 x 36 fifo, port a writes and port b reads, plus two mailboxes
// port clocks arrive as ordinary inputs synchronous to i_clock and are edge detected;
// both must run well below half of i_clock. bus pins are split into in, out and enable.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.vh"

// Functional notes
// - reset clears pointers, full/empty/almost-empty low, almost-full high
// - reset sets both mailbox indicators high, meaning no unread mail
// - full flag rises on the second port-a clock edge after reset release
// - offset latched at reset release: 16, 12, 8 or 4 from select pins
// - port-a bus driven with second mailbox only when select and write/read low
// - port-a fifo write when selected, writing, enabled, no mailbox, not full
// - port-a mailbox write fills first mailbox; mailbox read clears second indicator
// - port-b bus driven when selected and reading: first mailbox or output register
// - port-b fifo read when selected, reading, enabled, not empty, width not mailbox
// - port-b mailbox write fills second mailbox; mailbox read clears first indicator
// - flags pass two stages: full sides on port a, empty sides on port b
// - empty low at zero words; almost-empty low up to offset words
// - almost-full low from 64 minus offset words; full low at 64
// - reads while empty are ignored, pointer and output register hold
// - empty drops on the port-b edge that reads the final stored word
// - read pointer advances with each word moved to the output register
// - written word readable on the third port-b cycle after the write
// - writes while full are ignored, memory and pointer hold
// - write pointer advances with each word written to memory
// - freed location writable on the third port-a cycle after the read
// - writes to an unread mailbox are ignored; contents persist after reading
// - mailbox write drives its indicator low on the storing edge
module dcf_fifo #(
	parameter DATA_W = `DCF_DATA_W,
	parameter DEPTH = `DCF_DEPTH,
	parameter ADDR_W = `DCF_ADDR_W,
	parameter PTR_W = `DCF_PTR_W
) (
	input wire i_clock, // system clock, 200 MHz
	input wire i_nrst, // asynchronous reset, active low
	input wire i_port_a_clock, // port a clock, sampled
	input wire i_port_b_clock, // port b clock, sampled
	input wire i_offset_select_lo, // offset select, low bit
	input wire i_offset_select_hi, // offset select, high bit
	input wire i_port_a_select_n, // port a chip select, active low
	input wire i_port_a_write_not_read, // port a write high, read low
	input wire i_port_a_enable, // port a transfer enable
	input wire i_port_a_mailbox_select, // port a mailbox access
	input wire [DATA_W-1:0] i_port_a_bus, // port a bus, input side
	output reg [DATA_W-1:0] o_port_a_bus, // port a bus, output side
	output reg o_port_a_bus_oe, // port a bus drive enable
	input wire i_port_b_select_n, // port b chip select, active low
	input wire i_port_b_write_not_read, // port b write high, read low
	input wire i_port_b_enable, // port b transfer enable
	input wire i_port_b_width_sel_lo, // port b size select, low bit
	input wire i_port_b_width_sel_hi, // port b size select, high bit
	input wire [DATA_W-1:0] i_port_b_bus, // port b bus, input side
	output reg [DATA_W-1:0] o_port_b_bus, // port b bus, output side
	output reg o_port_b_bus_oe, // port b bus drive enable
	output reg o_port_a_full_flag_n, // full, active low, port a side
	output reg o_almost_full_flag_n, // almost full, active low
	output reg o_port_b_empty_flag_n, // empty, active low, port b side
	output reg o_almost_empty_flag_n, // almost empty, active low
	output reg o_mailbox_one_full_n, // first mailbox holds mail when low
	output reg o_mailbox_two_full_n // second mailbox holds mail when low
);

	// number of words between two pointers carrying a wrap bit
	function [PTR_W-1:0] fill_count;
		input [PTR_W-1:0] wp;
		input [PTR_W-1:0] rp;
		fill_count = wp - rp;
	endfunction

	reg [DATA_W-1:0] mem [0:DEPTH-1];
	reg port_a_clock_prev_q;
	reg port_b_clock_prev_q;
	reg [PTR_W-1:0] wptr_q;
	reg [PTR_W-1:0] rptr_q;
	reg [PTR_W-1:0] rptr_a1_q;
	reg [PTR_W-1:0] wptr_b1_q;
	reg rdy_a_q;
	reg ofs_loaded_q;
	reg [PTR_W-1:0] offset_q;
	reg [DATA_W-1:0] outreg_q;
	reg [DATA_W-1:0] mbox1_q;
	reg [DATA_W-1:0] mbox2_q;

	wire a_edge = i_port_a_clock & ~port_a_clock_prev_q;
	wire b_edge = i_port_b_clock & ~port_b_clock_prev_q;
	wire a_sel = ~i_port_a_select_n & i_port_a_enable;
	wire b_sel = ~i_port_b_select_n & i_port_b_enable;
	wire b_mbox = i_port_b_width_sel_lo & i_port_b_width_sel_hi;

	wire fifo_wr = a_edge & a_sel & i_port_a_write_not_read & ~i_port_a_mailbox_select
		& o_port_a_full_flag_n;
	wire fifo_rd = b_edge & b_sel & ~i_port_b_write_not_read & ~b_mbox
		& o_port_b_empty_flag_n;
	wire mb1_wr = a_edge & a_sel & i_port_a_write_not_read & i_port_a_mailbox_select
		& o_mailbox_one_full_n;
	wire mb2_rd = a_edge & a_sel & ~i_port_a_write_not_read & i_port_a_mailbox_select;
	wire mb2_wr = b_edge & b_sel & i_port_b_write_not_read & b_mbox
		& o_mailbox_two_full_n;
	wire mb1_rd = b_edge & b_sel & ~i_port_b_write_not_read & b_mbox;

	wire [PTR_W-1:0] wptr_d = fifo_wr ? wptr_q + 1'b1 : wptr_q;
	wire [PTR_W-1:0] rptr_d = fifo_rd ? rptr_q + 1'b1 : rptr_q;
	// fill as seen by each side: own pointer at once, far pointer after two stages
	wire [PTR_W-1:0] cnt_a = fill_count(wptr_d, rptr_a1_q);
	wire [PTR_W-1:0] cnt_b = fill_count(wptr_b1_q, rptr_d);
	localparam [PTR_W-1:0] DEPTH_C = DEPTH;
	wire full_c = cnt_a != DEPTH_C;
	wire afull_c = cnt_a < (DEPTH_C - offset_q);
	wire empty_c = cnt_b != {PTR_W{1'b0}};
	wire aempty_c = cnt_b > offset_q;

	// held high in reset so a port clock already high at release is not taken as a rise
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			port_a_clock_prev_q <= 1'b1;
			port_b_clock_prev_q <= 1'b1;
		end else begin
			port_a_clock_prev_q <= i_port_a_clock;
			port_b_clock_prev_q <= i_port_b_clock;
		end
	end

	// offset is taken on the first system clock after release, since an async
	// reset may only load constants
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ofs_loaded_q <= 1'b0;
			offset_q <= `DCF_OFS_RST;
		end else if (!ofs_loaded_q) begin
			ofs_loaded_q <= 1'b1;
			if (i_offset_select_hi && i_offset_select_lo) begin
				offset_q <= `DCF_OFS_HH;
			end else if (i_offset_select_hi) begin
				offset_q <= `DCF_OFS_HL;
			end else if (i_offset_select_lo) begin
				offset_q <= `DCF_OFS_LH;
			end else begin
				offset_q <= `DCF_OFS_LL;
			end
		end
	end

	// memory has no reset; it is only read after a word has been written
	always @(posedge i_clock) begin
		if (fifo_wr) begin
			mem[wptr_q[ADDR_W-1:0]] <= i_port_a_bus;
		end
	end

	// port a side: write pointer
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wptr_q <= {PTR_W{1'b0}};
		end else begin
			wptr_q <= wptr_d;
		end
	end

	// read pointer taken at one port-a rise and judged at the next one:
	// these are the two synchronising stages of full and almost-full
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rptr_a1_q <= {PTR_W{1'b0}};
		end else if (a_edge) begin
			rptr_a1_q <= rptr_q;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdy_a_q <= 1'b0;
		end else if (a_edge) begin
			rdy_a_q <= 1'b1;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_a_full_flag_n <= `DCF_FULL_N_RST;
		end else if (a_edge) begin
			o_port_a_full_flag_n <= rdy_a_q & full_c;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_almost_full_flag_n <= `DCF_AFULL_N_RST;
		end else if (a_edge) begin
			o_almost_full_flag_n <= afull_c;
		end
	end

	// port b side: read pointer
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rptr_q <= {PTR_W{1'b0}};
		end else begin
			rptr_q <= rptr_d;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wptr_b1_q <= {PTR_W{1'b0}};
		end else if (b_edge) begin
			wptr_b1_q <= wptr_q;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			outreg_q <= {DATA_W{1'b0}};
		end else if (fifo_rd) begin
			outreg_q <= mem[rptr_q[ADDR_W-1:0]];
		end
	end

	// reads are whole long words, so the last word read empties at once
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_b_empty_flag_n <= `DCF_EMPTY_N_RST;
		end else if (b_edge) begin
			o_port_b_empty_flag_n <= empty_c;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_almost_empty_flag_n <= `DCF_AEMPTY_N_RST;
		end else if (b_edge) begin
			o_almost_empty_flag_n <= aempty_c;
		end
	end

	// mailboxes; a write and a read landing together leave the indicator low
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mbox1_q <= {DATA_W{1'b0}};
		end else if (mb1_wr) begin
			mbox1_q <= i_port_a_bus;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mailbox_one_full_n <= `DCF_MBOX_N_RST;
		end else if (mb1_wr) begin
			o_mailbox_one_full_n <= 1'b0;
		end else if (mb1_rd) begin
			o_mailbox_one_full_n <= 1'b1;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mbox2_q <= {DATA_W{1'b0}};
		end else if (mb2_wr) begin
			mbox2_q <= i_port_b_bus;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mailbox_two_full_n <= `DCF_MBOX_N_RST;
		end else if (mb2_wr) begin
			o_mailbox_two_full_n <= 1'b0;
		end else if (mb2_rd) begin
			o_mailbox_two_full_n <= 1'b1;
		end
	end

	// bus drivers are registered, so drive and data follow the pins by one system clock
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_a_bus_oe <= 1'b0;
		end else begin
			o_port_a_bus_oe <= ~i_port_a_select_n & ~i_port_a_write_not_read;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_a_bus <= {DATA_W{1'b0}};
		end else begin
			o_port_a_bus <= mbox2_q;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_b_bus_oe <= 1'b0;
		end else begin
			o_port_b_bus_oe <= ~i_port_b_select_n & ~i_port_b_write_not_read;
		end
	end

	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_b_bus <= {DATA_W{1'b0}};
		end else begin
			o_port_b_bus <= b_mbox ? mbox1_q : outreg_q;
		end
	end

endmodule
`default_nettype wire

// ==== verification/dcf_fifo_checker.sv ====
// port-level assertions for the fifo core
// assumes port clocks are sampled on i_clock, so port events lag their rise by one edge
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_checker (
	input wire i_clock, // clk
	input wire i_nrst, // rst
	input wire i_port_a_clock, // a clk
	input wire i_port_b_clock, // b clk
	input wire i_port_a_select_n, // a cs
	input wire i_port_a_write_not_read, // a w/r
	input wire i_port_a_enable, // a en
	input wire i_port_a_mailbox_select, // a mbx
	input wire i_port_b_select_n, // b cs
	input wire i_port_b_write_not_read, // b w/r
	input wire i_port_b_enable, // b en
	input wire i_port_b_width_sel_lo, // b sz
	input wire i_port_b_width_sel_hi, // b sz
	input wire o_port_a_bus_oe, // a oe
	input wire o_port_b_bus_oe, // b oe
	input wire o_port_a_full_flag_n, // full
	input wire o_port_b_empty_flag_n, // empty
	input wire o_mailbox_one_full_n, // mb1
	input wire o_mailbox_two_full_n // mb2
);
	wire a_go = !i_port_a_select_n && i_port_a_enable;
	wire b_go = !i_port_b_select_n && i_port_b_enable;
	wire b_mb = i_port_b_width_sel_lo && i_port_b_width_sel_hi;
	wire a_on = !i_port_a_select_n && !i_port_a_write_not_read;
	wire b_on = !i_port_b_select_n && !i_port_b_write_not_read;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);
	sequence a_rise;
		$rose(i_port_a_clock);
	endsequence
	sequence b_rise;
		$rose(i_port_b_clock);
	endsequence
	AST_RST_VAL: assert property ($rose(i_nrst) |-> !o_port_a_full_flag_n &&
		!o_port_b_empty_flag_n && o_mailbox_one_full_n && o_mailbox_two_full_n)
		else $error("flags not at reset values");
	// the drive enables are registered, so the edge before must be out of reset
	AST_OE_A: assert property (($stable(a_on) && $past(i_nrst)) [*2] |-> o_port_a_bus_oe == a_on)
		else $error("port a drive wrong");
	AST_OE_B: assert property (($stable(b_on) && $past(i_nrst)) [*2] |-> o_port_b_bus_oe == b_on)
		else $error("port b drive wrong");
	AST_MB1_SET: assert property (a_rise ##0 (a_go && i_port_a_write_not_read &&
		i_port_a_mailbox_select && o_mailbox_one_full_n) |=> !o_mailbox_one_full_n)
		else $error("mail one flag not set");
	AST_MB1_CLR: assert property (b_rise ##0 (b_go && !i_port_b_write_not_read && b_mb)
		|=> o_mailbox_one_full_n) else $error("mail one flag not cleared");
	AST_MB2_SET: assert property (b_rise ##0 (b_go && i_port_b_write_not_read && b_mb
		&& o_mailbox_two_full_n) |=> !o_mailbox_two_full_n) else $error("mail two flag not set");
	AST_MB2_CLR: assert property (a_rise ##0 (a_go && !i_port_a_write_not_read &&
		i_port_a_mailbox_select) |=> o_mailbox_two_full_n) else $error("mail two flag kept");
	AST_FULL_HOLD: assert property (!$rose(i_port_a_clock) |=> $stable(o_port_a_full_flag_n))
		else $error("full moved off a port a edge");
	AST_EMPTY_HOLD: assert property (!$rose(i_port_b_clock) |=> $stable(o_port_b_empty_flag_n))
		else $error("empty moved off a port b edge");
endmodule
`default_nettype wire

// ==== verification/dcf_fifo_tb_top.sv ====
// bench for the fifo core: flags per offset, fill past full, drain past empty, mailboxes
// assumes port clocks from dcf_port_clk_model; port b data is checked by a queue monitor
`timescale 1ns/1ps
`default_nettype none
bind dcf_fifo dcf_fifo_checker dcf_fifo_checker_inst (.*);
module dcf_fifo_tb_top;
	logic i_clock = 1'b0, i_nrst = 1'b0, i_port_a_clock, i_port_b_clock;
	logic i_offset_select_lo = 1'b0, i_offset_select_hi = 1'b0, i_port_a_select_n = 1'b0;
	logic i_port_a_write_not_read = 1'b1, i_port_a_enable = 1'b0, i_port_a_mailbox_select = 1'b0;
	logic i_port_b_select_n = 1'b0, i_port_b_write_not_read = 1'b0, i_port_b_enable = 1'b0;
	logic i_port_b_width_sel_lo = 1'b0, i_port_b_width_sel_hi = 1'b0;
	logic [35:0] i_port_a_bus = 36'h0, i_port_b_bus = 36'h0, o_port_a_bus, o_port_b_bus, q[$];
	logic o_port_a_bus_oe, o_port_b_bus_oe, o_port_a_full_flag_n, o_almost_full_flag_n;
	logic o_port_b_empty_flag_n, o_almost_empty_flag_n, o_mailbox_one_full_n, o_mailbox_two_full_n;
	logic [35:0] seed = 36'h11;
	int error_cnt = 0, num_checks = 0;
	event rd_ev;
	dcf_fifo dcf_fifo_inst (.*);
	dcf_port_clk_model dcf_port_clk_model_inst (.i_clock(i_clock),
		.o_port_a_clock(i_port_a_clock), .o_port_b_clock(i_port_b_clock));
	initial forever #2.5 i_clock = ~i_clock;
	function automatic logic [35:0] lfsr(input logic [35:0] s);
		lfsr = {s[34:0], s[35] ^ s[24]};
	endfunction
	task automatic chk_d(input string n, input logic [35:0] e, input logic [35:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic pa_op(input logic w, input logic m, input logic [35:0] d);
		@(posedge i_port_a_clock);
		@(posedge i_clock);
		#1 {i_port_a_write_not_read, i_port_a_mailbox_select, i_port_a_bus} = {w, m, d};
		i_port_a_enable = 1'b1;
		@(posedge i_port_a_clock);
		@(posedge i_clock);
		#1 i_port_a_enable = 1'b0;
	endtask
	task automatic pb_op(input logic w, input logic m, input logic [35:0] d);
		@(posedge i_port_b_clock);
		@(posedge i_clock);
		#1 {i_port_b_write_not_read, i_port_b_width_sel_lo, i_port_b_width_sel_hi} = {w, m, m};
		{i_port_b_bus, i_port_b_enable} = {d, 1'b1};
		@(posedge i_port_b_clock);
		@(posedge i_clock);
		#1 i_port_b_enable = 1'b0;
		if (!w) ->rd_ev;
	endtask
	task automatic flags(input int m, input int x);
		repeat (3) @(posedge i_port_b_clock);
		@(posedge i_clock);
		#1 chk_d("flags", {32'h0, m > x, m < 64 - x, m < 64, m > 0}, {32'h0,
			o_almost_empty_flag_n, o_almost_full_flag_n, o_port_a_full_flag_n, o_port_b_empty_flag_n});
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial forever begin
		@(rd_ev);
		repeat (2) @(posedge i_clock);
		#1 chk_d("port b data", q.pop_front(), o_port_b_bus);
	end
	initial begin
		repeat (60000) @(posedge i_clock);
		error_cnt++;
		end_of_test;
	end
	initial begin
		for (int k = 0; k < 4; k++) begin
			i_nrst = 1'b0;
			{i_offset_select_hi, i_offset_select_lo} = k[1:0];
			@(posedge i_port_a_clock);
			repeat (20) @(posedge i_clock);
			chk_d("reset flags", 36'h7, {30'h0, o_port_a_full_flag_n, o_port_b_empty_flag_n,
				o_almost_empty_flag_n, o_almost_full_flag_n, o_mailbox_one_full_n, o_mailbox_two_full_n});
			#1 i_nrst = 1'b1;
			for (int i = 0; i < 2; i++) begin
				@(posedge i_port_a_clock);
				@(posedge i_clock);
				#1 chk_d("full after reset", 36'(i), 36'(o_port_a_full_flag_n));
			end
			for (int n = 1; n <= 65; n++) begin
				seed = lfsr(seed);
				if (n < 65) q.push_back(seed);
				pa_op(1'b1, 1'b0, seed);
				flags(n < 65 ? n : 64, 4 + 4 * k);
			end
			for (int n = 0; n < 65; n++) begin
				if (n == 64) q.push_back(q[$]);
				pb_op(1'b0, 1'b0, 36'h0);
			end
			flags(0, 4 + 4 * k);
			$display("offset test %0d done", k);
		end
		seed = lfsr(seed);
		pa_op(1'b1, 1'b1, seed);
		chk_d("mail one flag", 36'h0, 36'(o_mailbox_one_full_n));
		pa_op(1'b1, 1'b1, ~seed);
		q.push_back(seed);
		pb_op(1'b0, 1'b1, 36'h0);
		chk_d("mail one flag", 36'h1, 36'(o_mailbox_one_full_n));
		pb_op(1'b1, 1'b1, seed ^ 36'h5);
		chk_d("mail two flag", 36'h0, 36'(o_mailbox_two_full_n));
		pa_op(1'b0, 1'b1, 36'h0);
		chk_d("port a data", seed ^ 36'h5, o_port_a_bus);
		chk_d("mail two flag", 36'h1, 36'(o_mailbox_two_full_n));
		$display("mailbox test done");
		end_of_test;
	end
endmodule
`default_nettype wire

// ==== verification/dcf_port_clk_model.sv ====
// free-running port clocks of the two bus controllers
// assumes the core samples them on i_clock; each phase lasts two cycles
`timescale 1ns/1ps
`default_nettype none
module dcf_port_clk_model (
	input wire logic i_clock, // system clock
	output logic o_port_a_clock, // port a clock
	output logic o_port_b_clock // port b clock
);
	logic [1:0] cnt_q = 2'h0;
	logic [1:0] cnt_b;
	always @(posedge i_clock) cnt_q <= cnt_q + 2'h1;
	// b leads a by a cycle so the ports never share a detect edge
	assign cnt_b = cnt_q + 2'h1;
	assign o_port_a_clock = cnt_q[1];
	assign o_port_b_clock = cnt_b[1];
endmodule
`default_nettype wire
